// [logic/dspe_ctrl.sv]
// top of the dual section power enable controller
// assumes host drives both request pins asynchronously; regulator ready comes from analog
// assumes one core clock; the crystal reference belongs to the analog side
`timescale 1ns/1ps
module dspe_ctrl
    import dspe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // host requests
    input wire logic wlan_power_request,
    input wire logic shortrange_radio_power_request,
    // analog regulator ready
    input wire logic reg_ready,
    // software pull-down control, sampled like a pin
    input wire logic pd_disable_req,
    // outputs
    output logic regulator_en,
    output logic wlan_rst_n,
    output logic sr_rst_n,
    output logic wlan_pd_en,
    output logic sr_pd_en,
    output logic io_oe_n
);
    // reset copy, released through two flops
    logic rst_meta_q;
    logic rst_q;
    logic wlan_s;
    logic sr_s;
    logic rdy_s;
    logic pdd_s;
    dspe_state_t state_q;
    dspe_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_q <= rst_meta_q;
        end
    end

    // levels only: a pulse shorter than one clock may never reach the sequencer
    // pins come from the host domain
    dspe_sync u_wlan (.clk(clk), .rst_n(rst_q), .d(wlan_power_request), .q(wlan_s));
    dspe_sync u_sr (.clk(clk), .rst_n(rst_q), .d(shortrange_radio_power_request), .q(sr_s));
    dspe_sync u_rdy (.clk(clk), .rst_n(rst_q), .d(reg_ready), .q(rdy_s));
    dspe_sync u_pdd (.clk(clk), .rst_n(rst_q), .d(pd_disable_req), .q(pdd_s));

    wire any_req = wlan_s | sr_s;
    // the release count only moves while ready is seen; a dip pauses it
    wire ready_done = (state_q == DSPE_RAMP) && rdy_s && (cnt_q == dspe_rel_delay);

    // shutdown always drops to off, so every power-up starts cold
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            DSPE_OFF:
            begin
                cnt_d = 4'h0;
                if (any_req)
                    state_d = DSPE_RAMP;
            end
            DSPE_RAMP:
            begin
                if (!any_req)
                begin
                    state_d = DSPE_OFF;
                    cnt_d = 4'h0;
                end
                else if (ready_done)
                    state_d = DSPE_ON;
                else if (rdy_s && cnt_q != dspe_rel_delay)
                    cnt_d = cnt_q + 4'h1;
            end
            DSPE_ON:
            begin
                // dropping both requests ends the session at once
                if (!any_req)
                begin
                    state_d = DSPE_OFF;
                    cnt_d = 4'h0;
                end
            end
            default:
            begin
                state_d = DSPE_OFF;
                cnt_d = 4'h0;
            end
        endcase
    end

    // next values of the outputs; the flops below only copy them
    wire on_next = (state_d == DSPE_ON);
    // regulators follow the requests at once; the section resets and the pin enable wait for the ramp
    wire regulator_en_d = any_req;
    wire wlan_rst_n_d = on_next && wlan_s;
    wire sr_rst_n_d = on_next && sr_s;
    wire pd_en_d = ~pdd_s;
    // pins stay tristated through the ramp as well, trading a few cycles for no glitches
    wire io_oe_n_d = ~on_next;

    // sequencing state; a drop to off clears the count as well
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            state_q <= DSPE_OFF;
            cnt_q <= 4'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // regulator enable goes up as soon as either request is seen
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            regulator_en <= 1'b0;
        else
            regulator_en <= regulator_en_d;
    end

    // section resets only rise once the ramp has finished
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            wlan_rst_n <= 1'b0;
            sr_rst_n <= 1'b0;
        end
        else
        begin
            wlan_rst_n <= wlan_rst_n_d;
            sr_rst_n <= sr_rst_n_d;
        end
    end

    // both pull-downs share one control and come up enabled after reset
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            wlan_pd_en <= dspe_pd_reset;
            sr_pd_en <= dspe_pd_reset;
        end
        else
        begin
            wlan_pd_en <= pd_en_d;
            sr_pd_en <= pd_en_d;
        end
    end

    // outputs tristated while shut down
    always_ff @(posedge clk or negedge rst_q)
    begin
        if (!rst_q)
            io_oe_n <= 1'b1;
        else
            io_oe_n <= io_oe_n_d;
    end

    // requests and regulators
    a_reg_or: assert property (@(posedge clk) disable iff (!rst_q)
        regulator_en == $past(wlan_s | sr_s)) else $error("regulator enable not or");
    a_reg_off_both: assert property (@(posedge clk) disable iff (!rst_q)
        (!wlan_s && !sr_s) |=> !regulator_en) else $error("regulator on with no request");
    a_wlan_reg_on: assert property (@(posedge clk) disable iff (!rst_q)
        wlan_s |=> regulator_en) else $error("regulator off with wlan request");
    a_sr_reg_on: assert property (@(posedge clk) disable iff (!rst_q)
        sr_s |=> regulator_en) else $error("regulator off with short range request");

    // section resets
    a_wlan_reset_low: assert property (@(posedge clk) disable iff (!rst_q)
        !wlan_s |=> !wlan_rst_n) else $error("wlan left reset without request");
    a_sr_reset_low: assert property (@(posedge clk) disable iff (!rst_q)
        !sr_s |=> !sr_rst_n) else $error("short range left reset without request");
    a_wlan_release: assert property (@(posedge clk) disable iff (!rst_q)
        $rose(wlan_rst_n) |-> $past(rdy_s) && $past(wlan_s)) else $error("wlan release before ready");
    a_sr_release: assert property (@(posedge clk) disable iff (!rst_q)
        $rose(sr_rst_n) |-> $past(rdy_s) && $past(sr_s)) else $error("release before ready");
    a_ramp_held: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_RAMP) |-> !wlan_rst_n && !sr_rst_n) else $error("section released during ramp");
    a_ramp_wait: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_RAMP && !rdy_s) |=> state_q != DSPE_ON) else $error("ramp ended without ready");
    a_count_bound: assert property (@(posedge clk) disable iff (!rst_q)
        cnt_q <= dspe_rel_delay) else $error("release count overran");

    // shutdown, pins and pull-downs
    a_tristate_off: assert property (@(posedge clk) disable iff (!rst_q)
        !any_req |=> io_oe_n) else $error("outputs driven in shutdown");
    a_oe_ramp: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_RAMP) |-> io_oe_n) else $error("outputs driven during ramp");
    a_oe_when_on: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_ON) |-> !io_oe_n) else $error("outputs tristated while on");
    a_pd_follow: assert property (@(posedge clk) disable iff (!rst_q)
        pdd_s |=> !wlan_pd_en && !sr_pd_en) else $error("pull-down not disabled");
    a_pd_default: assert property (@(posedge clk) disable iff (!rst_q)
        !pdd_s |=> wlan_pd_en && sr_pd_en) else $error("pull-down not enabled");

    // every power-up starts from off with a clear count
    a_cold_start: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_OFF) |-> cnt_q == 4'h0) else $error("state kept over shutdown");
    a_drop_to_off: assert property (@(posedge clk) disable iff (!rst_q)
        !any_req |=> state_q == DSPE_OFF) else $error("no return to off without requests");
    a_off_no_release: assert property (@(posedge clk) disable iff (!rst_q)
        (state_q == DSPE_OFF) |-> !wlan_rst_n && !sr_rst_n) else $error("section released while off");
endmodule : dspe_ctrl

// [logic/dspe_pkg.sv]
// constants for the dual section power enable controller
// assumes a single 100 MHz core clock and host driven enable pins
package dspe_pkg;
    localparam int unsigned DSPE_CLK_MHZ = 100;
    localparam int unsigned DSPE_REF_KHZ = 40000;
    localparam int unsigned DSPE_SYNC_STAGES = 2;
    localparam logic dspe_pd_reset = 1'b1;
    localparam logic [3:0] dspe_rel_delay = 4'h2;

    typedef enum logic [1:0]
    {
        DSPE_OFF = 2'b00,
        DSPE_RAMP = 2'b01,
        DSPE_ON = 2'b11
    } dspe_state_t;
endpackage : dspe_pkg

// [logic/dspe_sync.sv]
// two flop synchroniser for one level
// assumes clk is the core clock and the input is asynchronous
`timescale 1ns/1ps
module dspe_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level
    input wire logic d,
    output logic q
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : dspe_sync

// [tb/dspe_host.sv]
// host model driving the request, ready and pull-down pins
// assumes the bench sets the wanted levels; pins change at falling edges
`timescale 1ns/1ps
module dspe_host
(
    // clock and wanted levels {wlan, short range, ready, pd disable}
    input wire logic clk,
    input wire logic [3:0] want,
    // pins
    output logic wl,
    output logic sr,
    output logic rdy,
    output logic pd,
    // reference clock the host supplies to the chip
    output logic ref_clk
);
    initial {wl, sr, rdy, pd} = 4'h0;
    // 40 MHz crystal reference, half period 12.5 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // levels are asynchronous to the device, so any edge is legal
    always @(negedge clk) {wl, sr, rdy, pd} <= want;
endmodule : dspe_host

// [tb/tb_dual_section_power_enable_ctrl.sv]
// self-checking bench for the dual section power enable controller
// assumes settled outputs within ten cycles of a pin change
`timescale 1ns/1ps
module tb_dual_section_power_enable_ctrl
    import dspe_pkg::*;
;
    localparam int unsigned ps_per_sec_khz = 32'h3b9aca00;
    logic clk = 1'b0;
    logic ref_clk;
    logic arst_n = 1'b0;
    logic [3:0] want = 4'h0;
    logic wl, sr, rdy, pd;
    wire [5:0] o;
    int errors = 0;
    int comparisons = 0;
    dspe_host host (.clk(clk), .want(want), .wl(wl), .sr(sr), .rdy(rdy), .pd(pd), .ref_clk(ref_clk));
    dspe_ctrl uut (.clk(clk), .arst_n(arst_n), .wlan_power_request(wl), .shortrange_radio_power_request(sr),
        .reg_ready(rdy), .pd_disable_req(pd), .regulator_en(o[5]), .wlan_rst_n(o[4]), .sr_rst_n(o[3]),
        .wlan_pd_en(o[2]), .sr_pd_en(o[1]), .io_oe_n(o[0]));
    initial forever #5 clk = ~clk;
    task stop_test;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    task chk(input logic [5:0] e);
        comparisons++;
        if (o !== e)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, o, e);
        end
    endtask : chk
    task chk_period(input int ps);
        comparisons++;
        if (ps != ps_per_sec_khz / DSPE_REF_KHZ)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, ps, ps_per_sec_khz / DSPE_REF_KHZ);
        end
    endtask : chk_period
    // sync plus sequencing needs only a handful of cycles; ten leaves margin
    task step(input logic [3:0] c);
        want = c;
        repeat (10) @(negedge clk);
    endtask : step
    task t_wlan;
        step(4'h2);
        chk(6'h07);
        step(4'ha);
        chk(6'h36);
        $display("wlan done");
    endtask : t_wlan
    task t_both;
        step(4'he);
        chk(6'h3e);
        step(4'h6);
        chk(6'h2e);
        step(4'h2);
        chk(6'h07);
        $display("both done");
    endtask : t_both
    // short range request alone from off: ramps, then releases only its own section
    task t_sr;
        step(4'h4);
        chk(6'h27);
        step(4'h6);
        chk(6'h2e);
        step(4'h2);
        chk(6'h07);
        $display("short range done");
    endtask : t_sr
    task t_ready;
        step(4'h8);
        chk(6'h27);
        step(4'ha);
        chk(6'h36);
        $display("ready done");
    endtask : t_ready
    task t_pd;
        step(4'h3);
        chk(6'h01);
        step(4'h2);
        chk(6'h07);
        $display("pulldown done");
    endtask : t_pd
    // a session dropped with ready low must ramp again from scratch
    task t_cold;
        step(4'ha);
        chk(6'h36);
        step(4'h0);
        chk(6'h07);
        step(4'h8);
        chk(6'h27);
        step(4'ha);
        chk(6'h36);
        step(4'h2);
        chk(6'h07);
        $display("cold start done");
    endtask : t_cold
    task t_reset;
        step(4'hb);
        chk(6'h30);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk(6'h07);
        arst_n = 1'b1;
        step(4'hb);
        chk(6'h30);
        $display("reset done");
    endtask : t_reset
    // the host's reference period must match the recommended crystal
    task t_ref;
        realtime t0;
        @(posedge ref_clk);
        t0 = $realtime;
        @(posedge ref_clk);
        chk_period(int'(($realtime - t0) * 1000.0));
        $display("reference done");
    endtask : t_ref
    initial
    begin
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        t_wlan();
        t_both();
        t_sr();
        t_ready();
        t_pd();
        t_cold();
        t_reset();
        t_ref();
        stop_test();
    end
    // about 200 cycles expected; a hang is cut well beyond that
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule : tb_dual_section_power_enable_ctrl
